// ==== hdl/sfs_status_readout.v ====
// status register readout over the serial port, sampled on clk
//
// Function
// (R1) select plus status opcode starts the readout
// (R2) bytes alternate first, second while clocked
// (R3) live status sampled for every repetition
// (R4) ready bit in both bytes, per byte
// (R5) select release ends readout, output released
// (R6) bit 7 low busy, high ready
// (R7) host polls until ready goes high
// (R8) first byte bit 6 compare mismatch
// (R9) first byte bits 5:2 density code
// (R10) first byte bit 1 protection enabled
// (R11) first byte bit 0 binary page size
// (R12) second byte bit 5 erase/program fault
// (R13) aborted operations leave fault clear
// (R14) fault rewritten at every completion
// (R15) second byte bit 3 lockdown available
// (R16) second buffer paused, its writes ignored
// (R17) first buffer paused, its writes ignored
// (R18) second byte bit 0 erase paused
// (R19) second byte bits 6, 4 zero
// (R20) msb first, first byte first
`include "sfs_status_regs.vh"

module sfs_status_readout #(
  // arbitrary value, not any real part's code
  parameter [3:0] DENSITY_CODE = `SFS_DENSITY_DEFAULT
) (
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // serial port pins
  input  wire       spi_sck,
  input  wire       spi_cs_n,
  input  wire       spi_mosi,
  output reg        spi_miso,
  output reg        spi_miso_oe,
  // live status from the internal machinery
  input  wire       busy,
  input  wire       compare_mismatch,
  input  wire       protect_enabled,
  input  wire       page_binary,
  input  wire       lockdown_available,
  input  wire       first_buffer_write_paused,
  input  wire       second_buffer_write_paused,
  input  wire       erase_paused,
  // completion of an erase or program
  input  wire       op_done,
  input  wire       op_failed,
  input  wire       op_aborted,
  // buffer alter gating
  input  wire       buf1_alter_req,
  input  wire       buf2_alter_req,
  output wire       buf1_alter_grant,
  output wire       buf2_alter_grant,
  // opcode hand-off to the command logic
  output reg  [7:0] cmd_opcode,
  output reg        cmd_valid,
  output wire       readout_active,
  // status byte taps
  output reg  [7:0] status_first_byte,
  output reg  [7:0] status_second_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // states

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_CMD    = 2'h1;
  localparam [1:0] ST_STATUS = 2'h2;
  localparam [1:0] ST_IGNORE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  wire [`SFS_SYNC_W-1:0] pin_sync;
  wire                   sck_s;
  wire                   cs_n_s;
  wire                   mosi_s;
  reg                    sck_prev;
  wire                   sck_rise;
  wire                   sck_fall;
  wire                   selected;
  wire                   erase_write_fault;

  reg  [1:0]             state;
  reg  [1:0]             next_state;
  reg  [7:0]             in_shift;
  wire [7:0]             next_in_shift;
  reg  [2:0]             in_cnt;
  reg  [7:0]             out_shift;
  reg  [2:0]             out_cnt;
  reg                    byte_sel;
  reg  [7:0]             next_first_byte;
  reg  [7:0]             next_second_byte;
  wire                   opcode_done;

  ////////////////////////////////////////////////////////////////////////////
  // pick the byte to send next

  function [7:0] pick_byte;
    input       sel;
    input [7:0] first_b;
    input [7:0] second_b;
    begin
      pick_byte = sel ? second_b : first_b;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; select resets deasserted

  sfs_sync2 #(
    .WIDTH    (`SFS_SYNC_W),
    .INIT     (`SFS_SYNC_RESET)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({spi_mosi, spi_cs_n, spi_sck}),
    .sync_out (pin_sync)
  );

  assign sck_s    = pin_sync[`SFS_SYNC_SCK];
  assign cs_n_s   = pin_sync[`SFS_SYNC_CS];
  assign mosi_s   = pin_sync[`SFS_SYNC_MOSI];
  assign selected = ~cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // serial clock edges, found on the synchronised copy

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_s;
    end
  end

  // mode 3 idles high: the first fall after select has no
  // bits counted yet and only moves the idle output
  assign sck_rise = sck_s & ~sck_prev;
  assign sck_fall = ~sck_s & sck_prev;

  ////////////////////////////////////////////////////////////////////////////
  // fault flag and buffer gating

  sfs_fault_track u_fault (
    .clk                        (clk),
    .reset_n                    (reset_n),
    .op_done                    (op_done),
    .op_failed                  (op_failed),
    .op_aborted                 (op_aborted),
    .first_buffer_write_paused  (first_buffer_write_paused),
    .second_buffer_write_paused (second_buffer_write_paused),
    .buf1_alter_req             (buf1_alter_req),
    .buf2_alter_req             (buf2_alter_req),
    .buf1_alter_grant           (buf1_alter_grant),
    .buf2_alter_grant           (buf2_alter_grant),
    .erase_write_fault          (erase_write_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // live status bytes

  always @* begin
    next_first_byte                    = `SFS_BYTE_RESET;
    next_first_byte[`SFS_B_READY]      = ~busy;              // see (R6)
    next_first_byte[`SFS_B1_COMPARE]   = compare_mismatch;   // see (R8)
    next_first_byte[`SFS_B1_DENSITY_HI:`SFS_B1_DENSITY_LO]
                                       = DENSITY_CODE;       // see (R9)
    next_first_byte[`SFS_B1_PROTECT]   = protect_enabled;    // see (R10)
    next_first_byte[`SFS_B1_PAGE]      = page_binary;        // see (R11)
  end

  always @* begin
    next_second_byte                   = `SFS_BYTE_RESET;
    next_second_byte[`SFS_B_READY]     = ~busy;              // see (R4)
    next_second_byte[`SFS_B2_RSV_HI]   = 1'b0;               // see (R19)
    next_second_byte[`SFS_B2_FAULT]    = erase_write_fault;  // see (R12)
    next_second_byte[`SFS_B2_RSV_LO]   = 1'b0;               // see (R19)
    next_second_byte[`SFS_B2_LOCKDOWN] = lockdown_available; // see (R15)
    next_second_byte[`SFS_B2_PAUSE2]   = second_buffer_write_paused; // see (R16)
    next_second_byte[`SFS_B2_PAUSE1]   = first_buffer_write_paused;  // see (R17)
    next_second_byte[`SFS_B2_ERASE]    = erase_paused;       // see (R18)
  end

  // taps follow the live value one clock behind
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_first_byte  <= `SFS_BYTE_RESET;
      status_second_byte <= `SFS_BYTE_RESET;
    end else begin
      status_first_byte  <= next_first_byte;
      status_second_byte <= next_second_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // opcode capture on rising edges, msb first

  assign next_in_shift = {in_shift[6:0], mosi_s};
  assign opcode_done   = (state == ST_CMD) && sck_rise &&
                         (in_cnt == `SFS_BIT_LAST);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      in_shift <= `SFS_BYTE_RESET;
      in_cnt   <= `SFS_CNT_ZERO;
    end else if (state != ST_CMD) begin
      in_shift <= `SFS_BYTE_RESET;
      in_cnt   <= `SFS_CNT_ZERO;
    end else if (sck_rise) begin
      in_shift <= next_in_shift;
      in_cnt   <= in_cnt + `SFS_CNT_ONE;
    end
  end

  // every opcode is handed on; only the status read is served here
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_opcode <= `SFS_BYTE_RESET;
      cmd_valid  <= 1'b0;
    end else begin
      cmd_valid <= opcode_done;
      if (opcode_done) begin
        cmd_opcode <= next_in_shift;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame state

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (selected) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (opcode_done) begin
          if (next_in_shift == `SFS_OP_STATUS_READ) begin
            next_state = ST_STATUS;                          // see (R1)
          end else begin
            next_state = ST_IGNORE;
          end
        end
      end
      ST_STATUS: begin
        next_state = ST_STATUS;
      end
      ST_IGNORE: begin
        next_state = ST_IGNORE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // release wins from any state, even mid-byte
    if (!selected) begin
      next_state = ST_IDLE;                                  // see (R5)
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign readout_active = (state == ST_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // status shifter: new bit on each falling edge

  // a byte is loaded only when the previous one is spent, so the
  // ready bit and every field are fresh at each byte start
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      out_shift <= `SFS_BYTE_RESET;
      out_cnt   <= `SFS_CNT_ZERO;
      byte_sel  <= 1'b0;
    end else if (state != ST_STATUS) begin
      out_shift <= `SFS_BYTE_RESET;
      out_cnt   <= `SFS_CNT_ZERO;
      byte_sel  <= 1'b0;                                     // see (R20)
    end else if (sck_fall) begin
      if (out_cnt == `SFS_CNT_ZERO) begin
        out_shift <= pick_byte(byte_sel, next_first_byte,
                               next_second_byte);            // see (R3) (R4)
        out_cnt   <= `SFS_BIT_LAST;
        byte_sel  <= ~byte_sel;                              // see (R2)
      end else begin
        out_shift <= {out_shift[6:0], 1'b0};                 // see (R20)
        out_cnt   <= out_cnt - `SFS_CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pin; enable only inside a status frame

  // drive follows the shifter a clock late, well inside the
  // slow serial clock's low phase
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= out_shift[`SFS_B_READY];
      spi_miso_oe <= (state == ST_STATUS) && selected;       // see (R5)
    end
  end

endmodule // sfs_status_readout

// ==== hdl/sfs_status_regs.vh ====
// constants for the serial flash status readout block
`ifndef SFS_STATUS_REGS_VH
`define SFS_STATUS_REGS_VH

// opcode that starts a status readout
`define SFS_OP_STATUS_READ  8'hD7

// byte and counter geometry
`define SFS_BYTE_W          8
`define SFS_BIT_LAST        3'h7
`define SFS_CNT_ZERO        3'h0
`define SFS_CNT_ONE         3'h1
`define SFS_SYNC_W          3

// reset values
`define SFS_BYTE_RESET      8'h00
`define SFS_SYNC_RESET      3'h2
`define SFS_FAULT_RESET     1'b0

// arbitrary neutral density family code
`define SFS_DENSITY_DEFAULT 4'h5

// bit positions common to both status bytes
`define SFS_B_READY         7

// first status byte
`define SFS_B1_COMPARE      6
`define SFS_B1_DENSITY_HI   5
`define SFS_B1_DENSITY_LO   2
`define SFS_B1_PROTECT      1
`define SFS_B1_PAGE         0

// second status byte
`define SFS_B2_RSV_HI       6
`define SFS_B2_FAULT        5
`define SFS_B2_RSV_LO       4
`define SFS_B2_LOCKDOWN     3
`define SFS_B2_PAUSE2       2
`define SFS_B2_PAUSE1       1
`define SFS_B2_ERASE        0

// sync bit positions
`define SFS_SYNC_SCK        0
`define SFS_SYNC_CS         1
`define SFS_SYNC_MOSI       2

`endif

// ==== hdl/sfs_sync2.v ====
// two flip-flop synchroniser for a group of pin inputs
module sfs_sync2 #(
  parameter                 WIDTH = 1,
  parameter [WIDTH-1:0]     INIT  = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire               clk,
  input  wire               reset_n,
  // asynchronous inputs
  input  wire [WIDTH-1:0]   async_in,
  // synchronised outputs
  output wire [WIDTH-1:0]   sync_out
);

  genvar i;

  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage_a;
      reg stage_b;
      // stage_a feeds stage_b only
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage_a <= INIT[i];
          stage_b <= INIT[i];
        end else begin
          stage_a <= async_in[i];
          stage_b <= stage_a;
        end
      end
      assign sync_out[i] = stage_b;
    end
  endgenerate

endmodule // sfs_sync2

// ==== hdl/sfs_fault_track.v ====
// erase/program fault flag and buffer write gating
`include "sfs_status_regs.vh"

module sfs_fault_track (
  // clock and reset
  input  wire clk,
  input  wire reset_n,
  // completion of an erase or program
  input  wire op_done,
  input  wire op_failed,
  input  wire op_aborted,
  // suspend state of each buffer
  input  wire first_buffer_write_paused,
  input  wire second_buffer_write_paused,
  // buffer alter requests and grants
  input  wire buf1_alter_req,
  input  wire buf2_alter_req,
  output wire buf1_alter_grant,
  output wire buf2_alter_grant,
  // fault flag
  output reg  erase_write_fault
);

  // rewritten on every completion; an abort is no fault
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      erase_write_fault <= `SFS_FAULT_RESET;
    end else if (op_done) begin
      erase_write_fault <= op_failed & ~op_aborted; // see (R12) (R13) (R14)
    end
  end

  // a suspended program owns its buffer until resumed
  assign buf1_alter_grant = buf1_alter_req & ~first_buffer_write_paused;  // see (R17)
  assign buf2_alter_grant = buf2_alter_req & ~second_buffer_write_paused; // see (R16)

endmodule // sfs_fault_track

// ==== verification/sfs_status_readout_checker.sv ====
// port checker for the status readout block
module sfs_status_readout_checker #(
  parameter [3:0] DENSITY_CODE = 4'h5
) (
  input logic       clk, reset_n, spi_sck, spi_cs_n, spi_mosi,
  input logic       spi_miso, spi_miso_oe, busy, compare_mismatch,
  input logic       protect_enabled, page_binary, lockdown_available,
  input logic       first_buffer_write_paused, second_buffer_write_paused,
  input logic       erase_paused, op_done, op_failed, op_aborted,
  input logic       buf1_alter_req, buf2_alter_req, buf1_alter_grant,
  input logic       buf2_alter_grant, cmd_valid, readout_active,
  input logic [7:0] cmd_opcode, status_first_byte, status_second_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  grant_one_a: assert property (buf1_alter_grant ==
    (buf1_alter_req && !first_buffer_write_paused)) else $error("grant 1");
  grant_two_a: assert property (buf2_alter_grant ==
    (buf2_alter_req && !second_buffer_write_paused)) else $error("grant 2");
  first_tap_a: assert property ($past(reset_n) |->
    status_first_byte == {!$past(busy), $past(compare_mismatch),
    DENSITY_CODE, $past(protect_enabled), $past(page_binary)})
    else $error("first byte tap");
  second_tap_a: assert property ($past(reset_n) |->
    status_second_byte == {!$past(busy), 1'b0, status_second_byte[5], 1'b0,
    $past(lockdown_available), $past(second_buffer_write_paused),
    $past(first_buffer_write_paused), $past(erase_paused)})
    else $error("second byte tap");
  fault_flag_a: assert property (op_done |-> ##2
    status_second_byte[5] == $past(op_failed && !op_aborted, 2))
    else $error("fault flag");
  open_frame_a: assert property (cmd_valid && cmd_opcode == 8'hd7
    && !spi_cs_n |-> ##[1:2] spi_miso_oe) else $error("no drive");
  refuse_a: assert property (cmd_valid && cmd_opcode != 8'hd7
    |-> !spi_miso_oe [*8]) else $error("drive on other opcode");
  release_a: assert property (spi_cs_n [*6] |-> !spi_miso_oe)
    else $error("drive after deselect");
  end_frame_a: assert property ($fell(readout_active) |=>
    !spi_miso_oe) else $error("drive after frame");
  miso_hold_a: assert property (spi_sck [*2] |-> $stable(spi_miso))
    else $error("data moved while clock high");

  cover property (cmd_valid && cmd_opcode == 8'hd7);
  cover property (cmd_valid && cmd_opcode != 8'hd7);
  cover property (status_second_byte[5]);
endmodule // sfs_status_readout_checker

bind sfs_status_readout sfs_status_readout_checker #(
  .DENSITY_CODE(DENSITY_CODE)) i_chk (.*);

// ==== verification/sfs_host_model.sv ====
// serial host model that frames status readouts
module sfs_host_model (
  // serial port pins
  output logic spi_sck,
  output logic spi_cs_n,
  output logic spi_mosi,
  input  wire  spi_miso,
  input  wire  spi_miso_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic miso_line;
  // no pull on the data line, so a released line reads z
  assign miso_line = spi_miso_oe ? spi_miso : 1'bz;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // long low phase: device answers 3 to 4 clk after a fall
  task automatic frame(input logic [7:0] op, input int n,
                       output logic [31:0] got);
    got = '0;
    spi_cs_n = 1'b0;
    #500;
    for (int i = 0; i < 8 + n; i++) begin
      spi_mosi = (i < 8) ? op[7-i] : ~spi_mosi;
      #460 spi_sck = 1'b1;
      if (i >= 8) got = {got[30:0], miso_line};
      #240 spi_sck = 1'b0;
      #100;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #500;
  endtask
endmodule // sfs_host_model

// ==== verification/sfs_status_readout_test.sv ====
// self-checking bench for the status readout block
module sfs_status_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] DENS = 4'h9; // arbitrary density code
  logic clk, reset_n, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic busy, compare_mismatch, protect_enabled, page_binary, fault_exp;
  logic lockdown_available, first_buffer_write_paused, erase_paused;
  logic second_buffer_write_paused, op_done, op_failed, op_aborted;
  logic buf1_alter_req, buf2_alter_req, buf1_alter_grant, buf2_alter_grant;
  logic cmd_valid, readout_active;
  logic [7:0] cmd_opcode, status_first_byte, status_second_byte;
  logic [31:0] got;
  logic [15:0] e_busy;
  int err_total, samples_checked;

  sfs_status_readout #(.DENSITY_CODE(DENS)) i_dut (.*);
  sfs_host_model i_host (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] status_exp();
    return {~busy, compare_mismatch, DENS, protect_enabled, page_binary,
      ~busy, 1'b0, fault_exp, 1'b0, lockdown_available,
      second_buffer_write_paused, first_buffer_write_paused, erase_paused};
  endfunction
  task automatic end_sim;
    $display("checked %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_grant;
    for (int i = 0; i < 16; i++) begin
      {buf1_alter_req, buf2_alter_req, first_buffer_write_paused,
       second_buffer_write_paused} = i[3:0];
      #1;
      check("grants", {buf1_alter_grant, buf2_alter_grant},
        {buf1_alter_req & ~i[1], buf2_alter_req & ~i[0]});
    end
    $display("test grant done");
  endtask
  task automatic t_fields;
    for (int p = 0; p < 2; p++) begin
      {busy, compare_mismatch, protect_enabled, page_binary,
       lockdown_available, second_buffer_write_paused,
       first_buffer_write_paused, erase_paused} = p ? 8'h5a : 8'ha5;
      tick(2);
      i_host.frame(8'hd7, 32, got);
      check("pair", got, {2{status_exp()}});
    end
    check("opcode", cmd_opcode, 8'hd7);
    $display("test fields done");
  endtask
  task automatic t_fault;
    logic [1:0] cases [4] = '{2'b10, 2'b11, 2'b00, 2'b10};
    for (int i = 0; i < 4; i++) begin
      {op_failed, op_aborted} = cases[i];
      op_done = 1'b1;
      tick(1);
      op_done = 1'b0;
      tick(3);
      fault_exp = cases[i][1] & ~cases[i][0];
      check("fault", status_second_byte[5], fault_exp);
    end
    $display("test fault done");
  endtask
  task automatic t_poll;
    busy = 1'b1;
    tick(2);
    e_busy = status_exp();
    fork
      i_host.frame(8'hd7, 32, got);
      #16500 busy = 1'b0;
    join
    check("poll", got, {e_busy, status_exp()});
    $display("test poll done");
  endtask
  task automatic t_abort;
    i_host.frame(8'hd7, 4, got);
    check("partial", got[3:0], status_exp() >> 12);
    check("released", spi_miso_oe, 1'b0);
    i_host.frame(8'hd7, 8, got);
    check("restart", got[7:0], status_exp() >> 8);
    $display("test abort done");
  endtask
  task automatic t_refuse;
    i_host.frame(8'h0b, 8, got);
    check("other opcode", got, {24'h00_0000, 8'hzz});
    check("other code", cmd_opcode, 8'h0b);
    $display("test refuse done");
  endtask

  initial begin
    #1_000_000;
    err_total++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    reset_n = 1'b0;
    fault_exp = 1'b0;
    {busy, compare_mismatch, protect_enabled, page_binary, op_done,
     lockdown_available, first_buffer_write_paused, erase_paused,
     second_buffer_write_paused, op_failed, op_aborted, buf1_alter_req,
     buf2_alter_req} = '0;
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    tick(3);
    t_grant();
    t_fields();
    t_fault();
    t_poll();
    t_abort();
    t_refuse();
    end_sim();
  end
endmodule // sfs_status_readout_test
